//--- rqd_app_model.sv
// Application-side model feeding request descriptors over valid/ready.
// Assumes the bench sets mode and ARI before pushing descriptors.
`timescale 1ns/100ps
module rqd_app_model
  import rqd_pkg::*;
(
  // Clock and reset
  input  wire logic      mclk_in,
  input  wire logic      nrst_in,
  // Port setup and pacing
  input  wire rqd_mode_e mode_in,
  input  wire logic      ari_in,
  input  wire logic      gap_in,
  // Descriptor stream
  output logic           desc_valid_out,
  input  wire logic      desc_ready_in,
  output rqd_desc_s      desc_out
);
  rqd_desc_s q[$];

  // Shape a descriptor as the application must, then queue it
  function automatic rqd_desc_s push(input rqd_desc_s d);
    if (mode_in == RQD_MODE_EP)
      d.rid_en = 1'b0;
    if (mode_in == RQD_MODE_RP)
      d.rid_en = 1'b1;
    if (!d.rid_en)
      d.req_bus = 8'h5a;
    if (!d.rid_en && !ari_in)
      d.fn_dev[7:3] = 5'h1f;
    d.tag[7:6] = 2'h3;
    q.push_back(d);
    return d;
  endfunction

  // Hold while refused; scramble the bus when idle so stale data shows
  always @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      desc_valid_out <= 1'b0;
      desc_out       <= '0;
    end
    else if (desc_valid_out && !desc_ready_in)
      desc_valid_out <= 1'b1;
    else if (q.size() > 0 && !(gap_in && desc_valid_out))
    begin
      desc_valid_out <= 1'b1;
      desc_out       <= q.pop_front();
    end
    else
    begin
      desc_valid_out <= 1'b0;
      desc_out       <= ~desc_out;
    end
  end
endmodule

//--- rqd_fields.sv
// Requester descriptor field builder: requester ID, tag, completer ID, TC.
// Assumes descriptors arrive one per valid/ready beat and an AHB-Lite master.
`timescale 1ns/100ps
module rqd_fields
  import rqd_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        nrst_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic [31:0]      hrdata_out,
  // Captured IDs from received configuration requests
  input  wire logic        cfg_capture_in,
  input  wire logic [7:0]  cfg_bus_in,
  input  wire logic [4:0]  cfg_dev_in,
  // Descriptor stream in
  input  wire logic        desc_valid_in,
  output logic             desc_ready_out,
  input  wire rqd_desc_s   desc_in,
  // Header fields out
  output logic             hdr_valid_out,
  input  wire logic        hdr_ready_in,
  output rqd_hdr_s         hdr_out
);

  // Control and captured state
  logic [3:0]  ctrl_reg;
  logic [7:0]  cap_bus_reg;
  logic [4:0]  cap_dev_reg;
  logic [5:0]  tag_cnt_reg;
  logic [31:0] count_reg;
  logic        ari_en;
  logic        app_tag;

  // Bus data phase state
  logic        wr_ph_reg;
  logic        rd_ph_reg;
  logic [7:0]  addr_ph_reg;
  logic        addr_ok;

  // Datapath
  rqd_hdr_s    hdr_next;
  logic        push;
  logic        fifo_empty;
  logic [2:0]  fifo_level;

  assign ari_en  = ctrl_reg[RQD_CTRL_ARI_BIT];
  assign app_tag = ctrl_reg[RQD_CTRL_TAG_BIT];

  // Zero-wait slave; every access answers OKAY
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  // Only whole-word transfers at valid beats are taken
  assign addr_ok = hsel_in && hready_in && htrans_in[1] && hsize_in == RQD_HSIZE_WORD;

  // Address phase capture
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      wr_ph_reg   <= 1'b0;
      rd_ph_reg   <= 1'b0;
      addr_ph_reg <= 8'h00;
    end
    else if (hready_in)
    begin
      wr_ph_reg   <= addr_ok && hwrite_in;
      rd_ph_reg   <= addr_ok && !hwrite_in;
      addr_ph_reg <= haddr_in[7:0];
    end
  end

  // Control register write; unmapped writes are dropped
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ctrl_reg <= RQD_CTRL_RESET;
    end
    else if (wr_ph_reg && addr_ph_reg == RQD_OFS_CTRL)
    begin
      ctrl_reg <= hwdata_in[3:0];
    end
  end

  // Read mux straight off flops; unmapped reads return zero
  always_comb
  begin
    hrdata_out = 32'h0000_0000;
    if (rd_ph_reg)
    begin
      unique case (addr_ph_reg)
        RQD_OFS_CTRL:  hrdata_out = {28'h0, ctrl_reg};
        RQD_OFS_CAPT:  hrdata_out = {19'h0, cap_dev_reg, cap_bus_reg};
        RQD_OFS_STAT:  hrdata_out = {21'h0, fifo_level, 2'h0, tag_cnt_reg};
        RQD_OFS_COUNT: hrdata_out = count_reg;
        default:       hrdata_out = 32'h0000_0000;
      endcase
    end
  end

  // Bus and device numbers learned from configuration requests
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cap_bus_reg <= 8'h00;
      cap_dev_reg <= 5'h00;
    end
    else if (cfg_capture_in)
    begin
      cap_bus_reg <= cfg_bus_in;
      cap_dev_reg <= cfg_dev_in;
    end
  end

  // A descriptor is taken only when the buffer has room
  assign push = desc_valid_in && desc_ready_out;

  // Header field assembly
  always_comb
  begin
    hdr_next = '0;
    // Requester ID source chosen by the enable bit
    if (desc_in.rid_en)
    begin
      // Bus, device and function all from the descriptor
      hdr_next.req_id = {desc_in.req_bus, desc_in.fn_dev};
    end
    else if (ari_en)
    begin
      // ARI function number spans all eight bits
      hdr_next.req_id = {cap_bus_reg, desc_in.fn_dev};
    end
    else
    begin
      // Descriptor device bits are ignored here
      hdr_next.req_id = {cap_bus_reg, cap_dev_reg, desc_in.fn_dev[2:0]};
    end
    // Tag source; reserved bits never leak into the header
    if (!desc_in.is_np)
    begin
      hdr_next.tag = 8'h00;
    end
    else if (app_tag)
    begin
      hdr_next.tag = {RQD_TAG_RSV, desc_in.tag[RQD_TAG_W-1:0]};
    end
    else
    begin
      hdr_next.tag = {RQD_TAG_RSV, tag_cnt_reg};
    end
    // Completer ID only where routing uses it; zero otherwise
    if (desc_in.id_routed)
    begin
      hdr_next.cpl_bus = desc_in.cpl_id[15:8];
      if (ari_en)
      begin
        hdr_next.cpl_dev = 5'h00;
        hdr_next.cpl_fn  = desc_in.cpl_id[7:0];
      end
      else
      begin
        hdr_next.cpl_dev = desc_in.cpl_id[7:3];
        hdr_next.cpl_fn  = {5'h00, desc_in.cpl_id[2:0]};
      end
    end
    hdr_next.tc = desc_in.tc;
  end

  // Internal tag allocator advances on each own-tagged non-posted request
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      tag_cnt_reg <= 6'h00;
    end
    else if (push && desc_in.is_np && !app_tag)
    begin
      tag_cnt_reg <= tag_cnt_reg + 6'h01;
    end
  end

  // Descriptor counter for software visibility
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      count_reg <= 32'h0000_0000;
    end
    else if (push)
    begin
      count_reg <= count_reg + 32'h0000_0001;
    end
  end

  // Buffer decouples the builder from a stalling consumer
  rqd_fifo #(
    .W (RQD_HDR_W),
    .D (RQD_FIFO_DEPTH)
  ) u_fifo (
    .mclk_in      (mclk_in),
    .nrst_in      (nrst_in),
    .wr_valid_in  (desc_valid_in),
    .wr_ready_out (desc_ready_out),
    .wr_data_in   (hdr_next),
    .rd_valid_out (hdr_valid_out),
    .rd_ready_in  (hdr_ready_in),
    .rd_data_out  (hdr_out),
    .level_out    (fifo_level)
  );

  assign fifo_empty = (fifo_level == 3'h0);

  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_push_empty;
    push && fifo_empty;
  endsequence

  sequence s_np_push;
    push && desc_in.is_np;
  endsequence

  a_app_tag_use: assert property (
    s_np_push ##0 app_tag |-> hdr_next.tag == {2'h0, desc_in.tag[5:0]})
    else $error("app tag not taken from low six bits");

  a_own_tag_step: assert property (
    s_np_push ##0 !app_tag |-> hdr_next.tag == {2'h0, tag_cnt_reg}
      ##1 tag_cnt_reg == $past(tag_cnt_reg) + 6'h01)
    else $error("internal tag not used or not advanced");

  a_tag_hold: assert property (
    push && app_tag |=> tag_cnt_reg == $past(tag_cnt_reg))
    else $error("tag allocator moved under app tagging");

  a_cpl_unused: assert property (
    push && !desc_in.id_routed |-> hdr_next.cpl_bus == 8'h00
      && hdr_next.cpl_fn == 8'h00 && hdr_next.cpl_dev == 5'h00)
    else $error("completer ID filled when not routed by ID");

  a_cpl_legacy: assert property (
    push && desc_in.id_routed && !ari_en |->
      {hdr_next.cpl_bus, hdr_next.cpl_dev, hdr_next.cpl_fn[2:0]} == desc_in.cpl_id)
    else $error("legacy completer ID split wrong");

  a_cpl_ari: assert property (
    push && desc_in.id_routed && ari_en |->
      {hdr_next.cpl_bus, hdr_next.cpl_fn} == desc_in.cpl_id)
    else $error("ARI completer ID split wrong");

  a_rid_desc: assert property (
    push && desc_in.rid_en |-> hdr_next.req_id[15:8] == desc_in.req_bus
      && hdr_next.req_id[7:3] == desc_in.fn_dev[7:3])
    else $error("requester ID not from descriptor");

  a_rid_capt: assert property (
    push && !desc_in.rid_en && !ari_en |->
      hdr_next.req_id == {cap_bus_reg, cap_dev_reg, desc_in.fn_dev[2:0]})
    else $error("requester ID not from captured numbers");

  a_tc_through: assert property (
    s_push_empty |=> hdr_valid_out && hdr_out.tc == $past(desc_in.tc))
    else $error("traffic class not carried to header");

  a_cap_load: assert property (
    cfg_capture_in |=> cap_bus_reg == $past(cfg_bus_in)
      && cap_dev_reg == $past(cfg_dev_in))
    else $error("captured IDs not loaded");

  sequence s_ctrl_addr;
    addr_ok && hwrite_in && haddr_in[7:0] == RQD_OFS_CTRL;
  endsequence

  a_ctrl_land: assert property (
    s_ctrl_addr |=> ##1 ctrl_reg == $past(hwdata_in[3:0]))
    else $error("control write did not land");

  a_ctrl_hold: assert property (
    !(wr_ph_reg && addr_ph_reg == RQD_OFS_CTRL) |=> $stable(ctrl_reg))
    else $error("control changed without a write");

  a_count_step: assert property (
    push |=> count_reg == $past(count_reg) + 32'h0000_0001)
    else $error("descriptor count did not advance");

  a_count_hold: assert property (
    !push |=> $stable(count_reg))
    else $error("descriptor count moved without a descriptor");

  a_posted_tag: assert property (
    push && !desc_in.is_np |-> hdr_next.tag == 8'h00 ##1 $stable(tag_cnt_reg))
    else $error("posted request touched the tag allocator");

  a_tag_rsv: assert property (
    push |-> hdr_next.tag[7:6] == RQD_TAG_RSV)
    else $error("reserved tag bits reached the header");

  a_rid_ari: assert property (
    push && !desc_in.rid_en && ari_en |->
      hdr_next.req_id == {cap_bus_reg, desc_in.fn_dev})
    else $error("ARI requester ID not from captured bus");

  a_rid_fn: assert property (
    push && desc_in.rid_en |-> hdr_next.req_id[2:0] == desc_in.fn_dev[2:0])
    else $error("requester function not from descriptor");

  a_tc_copy: assert property (
    push |-> hdr_next.tc == desc_in.tc)
    else $error("traffic class altered");

  a_buf_refuse: assert property (
    desc_ready_out == (fifo_level < 3'(RQD_FIFO_DEPTH)))
    else $error("buffer ready does not match its level");

  a_hdr_valid: assert property (
    hdr_valid_out == !fifo_empty)
    else $error("header valid does not match buffer level");

  a_hdr_hold: assert property (
    hdr_valid_out && !hdr_ready_in |=> hdr_valid_out && $stable(hdr_out))
    else $error("header changed while stalled");

  a_rd_idle: assert property (
    !rd_ph_reg |-> hrdata_out == 32'h0000_0000)
    else $error("read data driven outside a read");

  a_cfg_hold: assert property (
    !cfg_capture_in |=> $stable(cap_bus_reg) && $stable(cap_dev_reg))
    else $error("captured IDs changed without a capture");

endmodule

//--- rqd_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock; full and empty are exact.
`timescale 1ns/100ps
module rqd_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset
  input  wire logic         mclk_in,
  input  wire logic         nrst_in,
  // Fill side
  input  wire logic         wr_valid_in,
  output logic              wr_ready_out,
  input  wire logic [W-1:0] wr_data_in,
  // Drain side
  output logic              rd_valid_out,
  input  wire logic         rd_ready_in,
  output logic [W-1:0]      rd_data_out,
  // Fill level
  output logic [$clog2(D):0] level_out
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem_reg [D];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0]   cnt_reg;
  logic          push;
  logic          pop;

  // Handshakes
  assign wr_ready_out = (cnt_reg < (AW+1)'(D)); // Refuses only when all D slots hold data
  assign rd_valid_out = (cnt_reg != '0);
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_valid_out && rd_ready_in;
  assign rd_data_out  = mem_reg[rp_reg];
  assign level_out    = cnt_reg;

  // Storage; no reset needed on data
  always_ff @(posedge mclk_in)
  begin
    if (push)
    begin
      mem_reg[wp_reg] <= wr_data_in;
    end
  end

  // Pointers and count
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_reg <= (wp_reg == AW'(D-1)) ? '0 : wp_reg + 1'b1;
      end
      if (pop)
      begin
        rp_reg <= (rp_reg == AW'(D-1)) ? '0 : rp_reg + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_reg <= cnt_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

//--- rqd_pkg.sv
// Constants and carrier types for the request descriptor field builder.
// Assumes one clock domain and the AHB-Lite register slave of rqd_fields.
// Functional notes
// - App tagging: tag from low six bits
// - Own tagging: internal tags, descriptor tag ignored
// - Completer ID only for config, ID-routed messages
// - No ARI: completer ID is bus/dev/fn 8/5/3
// - ARI: completer ID is bus plus 8-bit function
// - ID enable set: requester ID from descriptor
// - ID enable clear: captured bus, captured dev unless ARI, descriptor function
// - Enable set, no ARI: device from bits 87:83
// - Traffic class field tied to the request
package rqd_pkg;

  // Register byte offsets
  localparam logic [7:0] RQD_OFS_CTRL  = 8'h00;
  localparam logic [7:0] RQD_OFS_CAPT  = 8'h04;
  localparam logic [7:0] RQD_OFS_STAT  = 8'h08;
  localparam logic [7:0] RQD_OFS_COUNT = 8'h0c;

  // Control field positions and reset value
  localparam int         RQD_CTRL_ARI_BIT = 0;
  localparam int         RQD_CTRL_TAG_BIT = 1;
  localparam int         RQD_CTRL_MODE_LO = 2;
  localparam logic [3:0] RQD_CTRL_RESET   = 4'h0;

  // Tag layout: six usable bits, two reserved
  localparam int         RQD_TAG_W   = 6;
  localparam logic [1:0] RQD_TAG_RSV = 2'h0;

  // Buffer shape
  localparam int RQD_FIFO_DEPTH = 4;

  // AHB encodings
  localparam logic [1:0] RQD_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] RQD_HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] RQD_HSIZE_WORD    = 3'h2;

  // Port operating mode
  typedef enum logic [1:0] {
    RQD_MODE_EP   = 2'h0,
    RQD_MODE_SWUP = 2'h1,
    RQD_MODE_RP   = 2'h3
  } rqd_mode_e;

  // Descriptor bits 80..123 plus side flags
  typedef struct packed {
    logic [2:0]  tc;
    logic        rid_en;
    logic [15:0] cpl_id;
    logic [7:0]  tag;
    logic [7:0]  req_bus;
    logic [7:0]  fn_dev;
    logic        is_np;
    logic        id_routed;
  } rqd_desc_s;

  // Header fields handed to the packet builder
  typedef struct packed {
    logic [15:0] req_id;
    logic [7:0]  tag;
    logic [7:0]  cpl_bus;
    logic [4:0]  cpl_dev;
    logic [7:0]  cpl_fn;
    logic [2:0]  tc;
  } rqd_hdr_s;

  localparam int RQD_HDR_W = $bits(rqd_hdr_s);

endpackage

//--- tb_rq_descriptor_id_tag_tc_fields.sv
// Self-checking bench for the descriptor field builder.
// Assumes a zero-wait AHB-Lite slave and one 100 MHz clock.
`timescale 1ns/100ps
module tb_rq_descriptor_id_tag_tc_fields
  import rqd_pkg::*;
;
  logic        mclk_in;
  logic        nrst_in;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        cfg_cap;
  logic [7:0]  cfg_bus;
  logic [4:0]  cfg_dev;
  logic        desc_valid;
  logic        desc_ready;
  rqd_desc_s   desc;
  logic        hdr_valid;
  logic        hdr_ready;
  rqd_hdr_s    hdr;
  rqd_mode_e   mode;
  logic        ari;
  logic        app_tag;
  logic        gap;
  logic [5:0]  tcnt;
  logic [31:0] rd;
  int          num_errors;
  int          checks;
  int          sent;
  rqd_hdr_s    exp_q[$];

  rqd_fields i_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hreadyout), .hreadyout_out(hreadyout), .hresp_out(hresp),
    .hrdata_out(hrdata), .cfg_capture_in(cfg_cap), .cfg_bus_in(cfg_bus),
    .cfg_dev_in(cfg_dev), .desc_valid_in(desc_valid), .desc_ready_out(desc_ready),
    .desc_in(desc), .hdr_valid_out(hdr_valid), .hdr_ready_in(hdr_ready), .hdr_out(hdr));

  rqd_app_model i_app (.mclk_in(mclk_in), .nrst_in(nrst_in), .mode_in(mode), .ari_in(ari),
    .gap_in(gap), .desc_valid_out(desc_valid), .desc_ready_in(desc_ready),
    .desc_out(desc));

  // 100 MHz clock
  initial
  begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic finish_test;
    $display("Checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for hready at the next edges
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge mclk_in);
    while (hreadyout !== 1'b1 && n < 100)
    begin
      @(posedge mclk_in);
      n++;
    end
    if (n == 100)
    begin
      num_errors++;
      $display("Error %0t: bus timeout", $time);
      finish_test;
    end
  endtask

  // One single AHB-Lite word transfer
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] d);
    @(posedge mclk_in);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= RQD_HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy;
    d = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    ahb(1'b0, a, 32'h0, d);
    chk(d, e);
  endtask

  // Queue a descriptor and work out the header it must produce
  task automatic send(input rqd_desc_s d0);
    rqd_desc_s d;
    rqd_hdr_s  h;
    d = i_app.push(d0);
    h = '0;
    h.req_id = d.rid_en ? {d.req_bus, d.fn_dev} : ari ? {cfg_bus, d.fn_dev}
             : {cfg_bus, cfg_dev, d.fn_dev[2:0]};
    if (d.is_np && app_tag)
      h.tag = {2'h0, d.tag[5:0]};
    if (d.is_np && !app_tag)
    begin
      h.tag = {2'h0, tcnt};
      tcnt = tcnt + 6'h1;
    end
    if (d.id_routed)
      h.cpl_bus = d.cpl_id[15:8];
    if (d.id_routed && ari)
      h.cpl_fn = d.cpl_id[7:0];
    if (d.id_routed && !ari)
      {h.cpl_dev, h.cpl_fn} = {d.cpl_id[7:3], 5'h0, d.cpl_id[2:0]};
    h.tc = d.tc;
    exp_q.push_back(h);
    sent++;
  endtask

  task automatic drain;
    for (int n = 0; n < 200 && exp_q.size() > 0; n++)
      @(posedge mclk_in);
    if (exp_q.size() > 0)
    begin
      num_errors++;
      $display("Error %0t: headers missing", $time);
      finish_test;
    end
  endtask

  // Compare each header taken against the oldest expectation
  always @(posedge mclk_in)
  begin
    if (nrst_in && hdr_valid === 1'b1 && hdr_ready === 1'b1)
    begin
      checks++;
      if (exp_q.size() == 0 || hdr !== exp_q[0])
      begin
        num_errors++;
        $display("Error %0t: header %h wrong", $time, hdr);
      end
      if (exp_q.size() > 0)
        void'(exp_q.pop_front());
    end
  end

  initial
  begin
    {nrst_in, hsel, haddr, htrans, hwrite, hwdata, cfg_cap} = '0;
    {cfg_bus, cfg_dev, hdr_ready, gap, tcnt} = {8'ha5, 5'h13, 1'b1, 1'b0, 6'h0};
    mode = RQD_MODE_EP;
    {ari, app_tag} = 2'h0;
    repeat (16) @(posedge mclk_in);
    nrst_in <= 1'b1;
    rchk(RQD_OFS_CTRL, {28'h0, RQD_CTRL_RESET});
    rchk(RQD_OFS_CAPT, 32'h0);
    rchk(RQD_OFS_STAT, 32'h0);
    rchk(RQD_OFS_COUNT, 32'h0);
    rchk(8'h10, 32'h0);
    chk({30'h0, desc_ready, hdr_valid}, 32'h2);
    cfg_cap <= 1'b1;
    @(posedge mclk_in);
    cfg_cap <= 1'b0;
    ahb(1'b1, RQD_OFS_CAPT, 32'hffff_ffff, rd);
    ahb(1'b1, 8'h10, 32'hffff_ffff, rd);
    rchk(RQD_OFS_CAPT, {19'h0, cfg_dev, cfg_bus});
    $display("Reset and register test done");
    // Every mode with ARI and tagging choices
    for (int m = 0; m < 3; m++)
      for (int c = 0; c < 4; c++)
      begin
        mode = m == 0 ? RQD_MODE_EP : m == 1 ? RQD_MODE_SWUP : RQD_MODE_RP;
        {app_tag, ari} = c[1:0];
        gap <= c[0];
        ahb(1'b1, RQD_OFS_CTRL, {28'h0, mode, app_tag, ari}, rd);
        rchk(RQD_OFS_CTRL, {28'h0, mode, app_tag, ari});
        send({3'(c + m), 1'b1, 16'hc3a9, 8'h2d, 8'h71, 8'hb6, 2'h3});
        send({3'(c + 4), 1'b0, 16'h5e17, 8'h3c, 8'h44, 8'h69, 2'h1});
        send({3'(7 - m), 1'b0, 16'h9b62, 8'h3f, 8'h12, 8'h0d, 2'h2});
        drain;
      end
    $display("Mode test done");
    // Stall the far side until the buffer refuses
    hdr_ready <= 1'b0;
    repeat (5)
      send({3'h5, 1'b1, 16'h1234, 8'h01, 8'h02, 8'h03, 2'h3});
    repeat (10) @(posedge mclk_in);
    chk({31'h0, desc_ready}, 32'h0);
    rchk(RQD_OFS_STAT, {21'h0, 3'h4, 2'h0, tcnt});
    hdr_ready <= 1'b1;
    drain;
    @(posedge mclk_in);
    chk({31'h0, hdr_valid}, 32'h0);
    rchk(RQD_OFS_COUNT, 32'(sent));
    $display("Buffer test done");
    finish_test;
  end
endmodule
